// ===== logic/i2cms_pkg.sv
package i2cms_pkg;
  // baud generator reload width and reset value, transfer buffer reset value
  localparam int BRG_W = 8;
  localparam logic [7:0] BRG_RELOAD_RST = 8'h04;
  localparam logic [7:0] BUF_RST = 8'h00;
  // bit positions of the byte under arbitration, msb first
  localparam logic [2:0] BIT_MSB = 3'h7;
  // sequencer states
  typedef enum logic [3:0] {
    I2CMS_IDLE,
    I2CMS_HOLD,
    I2CMS_ACK_LOW,
    I2CMS_ACK_RISE,
    I2CMS_ACK_HIGH,
    I2CMS_STOP_SDA,
    I2CMS_STOP_LOW,
    I2CMS_STOP_RISE,
    I2CMS_STOP_SDAREL,
    I2CMS_STOP_WAITP,
    I2CMS_STOP_TAIL,
    I2CMS_LOST
  } i2cms_state_t;
endpackage

// ===== logic/i2cms_brg.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// baud rate generator: reload and count down to zero
// ----------------------------------------------------------------
module i2cms_brg
  import i2cms_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic run,
  input wire logic reload,
  input wire logic [BRG_W-1:0] reload_count,
  // status
  output logic tick
);
  logic [BRG_W-1:0] count;

  // a reload always wins so every period starts full length
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !run || reload) begin
      count <= reload_count; // [RQ18]
    end else if (count == '0) begin
      count <= reload_count;
    end else begin
      count <= count - 1'b1; // [RQ18]
    end
  end

  assign tick = run && !reload && (count == '0);
endmodule

// ===== logic/i2cms_core.sv
`timescale 1ns/100ps
// What this block does
// [RQ1] wait while slave holds clock low
// [RQ2] no new message while bus busy
// [RQ3] released data seen low loses arbitration
// [RQ4] loser releases clock, waits for stop
// [RQ5] lower address wins via wired low
// [RQ6] arbitration checked through data bytes too
// [RQ7] ack enable drives clock low, data value
// [RQ8] software sets ack data before enabling
// [RQ9] ack: tick, release clock, tick, low
// [RQ10] ack end clears enable, stops generator
// [RQ11] buffer write during ack sets collision
// [RQ12] hold clock low after ninth falling edge
// [RQ13] stop: data low, then reload generator
// [RQ14] expiry releases clock, data one tick later
// [RQ15] stop detected when data rises clock high
// [RQ16] tick after stop: clear enable, set irq
// [RQ17] buffer write during stop sets collision
// [RQ18] reload count decremented to zero each clock
module i2cms_core
  import i2cms_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // software control
  input wire logic [BRG_W-1:0] brg_reload,
  input wire logic ack_set,
  input wire logic ack_data_value,
  input wire logic stop_set,
  input wire logic byte_done,
  input wire logic tx_drive_bit,
  input wire logic tx_bit_valid,
  input wire logic start_req,
  input wire logic buf_wr,
  input wire logic [7:0] buf_wr_data,
  input wire logic write_collision_flag_clr,
  input wire logic irq_clr,
  input wire logic stop_det_clr,
  input wire logic arb_lost_clr,
  // status
  output logic ack_sequence_enable,
  output logic stop_sequence_enable,
  output logic write_collision_flag,
  output logic serial_irq_flag,
  output logic stop_detected,
  output logic start_detected,
  output logic bus_busy,
  output logic arb_lost,
  output logic start_grant,
  output logic [7:0] transfer_buffer
);
  i2cms_state_t state;
  i2cms_state_t next_state;
  logic brg_run;
  logic brg_reload_now;
  logic tick;
  logic scl_d;
  logic sda_d;
  logic seq_busy;
  logic stop_evt;
  logic start_evt;
  logic arb_evt;
  logic scl_low_req;
  logic sda_low_req;
  default clocking @(posedge sys_clk); endclocking

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  i2cms_brg u_brg (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(brg_run),
    .reload(brg_reload_now),
    .reload_count(brg_reload),
    .tick(tick)
  );

  // generator runs only inside a sequence, off in idle
  assign brg_run = (state != I2CMS_IDLE) && (state != I2CMS_HOLD)
    && (state != I2CMS_LOST); // [RQ10]

  // ----------------------------------------------------------------
  // bus watching
  // ----------------------------------------------------------------
  // previous line levels for start and stop edges
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end

  assign stop_evt = scl_in && scl_d && sda_in && !sda_d; // [RQ15]
  assign start_evt = scl_in && scl_d && !sda_in && sda_d;

  // busy from start until stop, set wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_busy <= 1'b0;
    end else if (start_evt) begin
      bus_busy <= 1'b1; // [RQ2]
    end else if (stop_evt) begin
      bus_busy <= 1'b0; // [RQ2]
    end
  end

  // new message allowed only on an idle bus and idle sequencer
  assign start_grant = start_req && !bus_busy && !start_evt
    && (state == I2CMS_IDLE) && !arb_lost; // [RQ2]

  // sticky start and stop flags, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stop_detected <= 1'b0;
      start_detected <= 1'b0;
    end else begin
      if (stop_evt) begin
        stop_detected <= 1'b1; // [RQ15]
      end else if (stop_det_clr) begin
        stop_detected <= 1'b0;
      end
      if (start_evt) begin
        start_detected <= 1'b1;
      end else if (stop_det_clr) begin
        start_detected <= 1'b0; // one clear pulse wipes both edge flags
      end
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  // checked on every clock-high bit, address or data alike, so a
  // lower address wins by its dominant low and equal ones go on
  assign arb_evt = tx_bit_valid && tx_drive_bit && scl_in
    && !sda_in; // [RQ3] [RQ5] [RQ6]

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      arb_lost <= 1'b0;
    end else if (arb_evt) begin
      arb_lost <= 1'b1; // [RQ3]
    end else if (arb_lost_clr) begin
      arb_lost <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    brg_reload_now = 1'b0;
    case (state)
      I2CMS_IDLE: begin
        if (byte_done) next_state = I2CMS_HOLD; // [RQ12]
      end
      I2CMS_HOLD: begin
        if (ack_set) begin
          next_state = I2CMS_ACK_LOW;
          brg_reload_now = 1'b1;
        end else if (stop_set) begin
          next_state = I2CMS_STOP_SDA;
        end
      end
      I2CMS_ACK_LOW: begin
        if (tick) next_state = I2CMS_ACK_RISE; // [RQ9]
      end
      I2CMS_ACK_RISE: begin
        brg_reload_now = 1'b1; // stretched clock keeps us here
        if (scl_in) begin
          next_state = I2CMS_ACK_HIGH; // [RQ1] [RQ9]
        end
      end
      I2CMS_ACK_HIGH: begin
        // park with clock low; letting both go would fake a stop
        if (tick) next_state = I2CMS_HOLD; // [RQ9] [RQ10]
      end
      I2CMS_STOP_SDA: begin
        brg_reload_now = 1'b1;
        if (!sda_in) begin
          next_state = I2CMS_STOP_LOW; // [RQ13]
        end
      end
      I2CMS_STOP_LOW: begin
        if (tick) next_state = I2CMS_STOP_RISE; // [RQ14]
      end
      I2CMS_STOP_RISE: begin
        brg_reload_now = !scl_in;
        if (scl_in && tick) begin
          next_state = I2CMS_STOP_WAITP; // [RQ1] [RQ14]
        end
      end
      I2CMS_STOP_WAITP: begin
        brg_reload_now = 1'b1;
        if (stop_evt) begin
          next_state = I2CMS_STOP_TAIL; // [RQ15]
        end
      end
      I2CMS_STOP_TAIL: begin
        if (tick) next_state = I2CMS_IDLE; // [RQ16]
      end
      I2CMS_LOST: begin
        if (stop_evt) next_state = I2CMS_IDLE; // [RQ4]
      end
      default: next_state = I2CMS_IDLE;
    endcase
    if (arb_evt) begin
      next_state = I2CMS_LOST; // [RQ4]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= I2CMS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // enable bits, set by software, cleared by hardware at the end
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_sequence_enable <= 1'b0;
    end else if (state == I2CMS_HOLD && ack_set) begin
      ack_sequence_enable <= 1'b1; // [RQ7]
    end else if (state == I2CMS_ACK_HIGH && tick) begin
      ack_sequence_enable <= 1'b0; // [RQ10]
    end else if (arb_evt) begin
      ack_sequence_enable <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stop_sequence_enable <= 1'b0;
    end else if (state == I2CMS_HOLD && stop_set && !ack_set) begin
      stop_sequence_enable <= 1'b1; // [RQ13]
    end else if (state == I2CMS_STOP_TAIL && tick) begin
      stop_sequence_enable <= 1'b0; // [RQ16]
    end else if (arb_evt) begin
      stop_sequence_enable <= 1'b0;
    end
  end

  // irq on stop completion, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_irq_flag <= 1'b0;
    end else if (state == I2CMS_STOP_TAIL && tick) begin
      serial_irq_flag <= 1'b1; // [RQ16]
    end else if (irq_clr) begin
      serial_irq_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transfer buffer and write collision
  // ----------------------------------------------------------------
  assign seq_busy = ack_sequence_enable || stop_sequence_enable;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      transfer_buffer <= BUF_RST;
    end else if (buf_wr && !seq_busy) begin
      transfer_buffer <= buf_wr_data; // [RQ11] [RQ17]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      write_collision_flag <= 1'b0;
    end else if (buf_wr && seq_busy) begin
      write_collision_flag <= 1'b1; // [RQ11] [RQ17]
    end else if (write_collision_flag_clr) begin
      write_collision_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin drive; output value always low, enable pulls the line
  // ----------------------------------------------------------------
  // a released line is not driven; the loser drops both lines
  always_comb begin
    scl_low_req = 1'b0;
    sda_low_req = 1'b0;
    case (state)
      I2CMS_HOLD: scl_low_req = 1'b1; // [RQ12]
      I2CMS_ACK_LOW: begin
        scl_low_req = 1'b1; // [RQ7]
        sda_low_req = !ack_data_value; // [RQ7] [RQ8]
      end
      I2CMS_ACK_RISE, I2CMS_ACK_HIGH: sda_low_req = !ack_data_value;
      I2CMS_STOP_SDA, I2CMS_STOP_LOW: begin
        scl_low_req = 1'b1;
        sda_low_req = 1'b1; // [RQ13]
      end
      I2CMS_STOP_RISE: sda_low_req = 1'b1; // [RQ14]
      default: sda_low_req = 1'b0; // idle, lost and stop tail let go [RQ4]
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= scl_low_req && !arb_evt;
      sda_oe <= sda_low_req && !arb_evt; // [RQ3]
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_WRITE_COLLISION_FLAG_ON_ACK: assert property (disable iff (sys_rst) // [RQ11]
    buf_wr && ack_sequence_enable |=> write_collision_flag)
    else $error("collision flag not set during ack");
  AST_BUF_KEPT: assert property (disable iff (sys_rst) // [RQ17]
    buf_wr && stop_sequence_enable |=> $stable(transfer_buffer))
    else $error("buffer changed during stop");
  AST_LOST_RELEASE: assert property (disable iff (sys_rst) // [RQ4]
    arb_evt |=> !scl_oe && !sda_oe)
    else $error("loser still drives lines");
  AST_LOST_FLAG: assert property (disable iff (sys_rst) // [RQ3]
    arb_evt |=> arb_lost)
    else $error("arbitration loss not flagged");
  AST_STOP_FLAG: assert property (disable iff (sys_rst) // [RQ15]
    stop_evt |=> stop_detected)
    else $error("stop not detected");
  AST_NO_GRANT_BUSY: assert property (disable iff (sys_rst) // [RQ2]
    start_evt |=> bus_busy && !start_grant)
    else $error("start seen but bus not busy");
  AST_ACK_END: assert property (disable iff (sys_rst) // [RQ10]
    state == I2CMS_ACK_HIGH && tick && !arb_evt |=>
    !ack_sequence_enable && state == I2CMS_HOLD)
    else $error("ack end not clean");
  AST_STOP_IRQ: assert property (disable iff (sys_rst) // [RQ16]
    state == I2CMS_STOP_TAIL && tick |=>
    serial_irq_flag && !stop_sequence_enable)
    else $error("stop end irq missing");
  AST_HOLD_LOW: assert property (disable iff (sys_rst) // [RQ12]
    state == I2CMS_HOLD && !arb_evt |=> scl_oe)
    else $error("clock not held low");
  AST_ACK_WAIT: assert property (disable iff (sys_rst) // [RQ1]
    state == I2CMS_ACK_RISE && !scl_in && !arb_evt
    |=> state == I2CMS_ACK_RISE)
    else $error("stretch not honoured");
endmodule

// ===== testbench/i2cms_bus_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// far side of the bus: slaves and other masters on a wired-and pair
// ----------------------------------------------------------------
module i2cms_bus_model (
  // design side pull-downs
  input wire logic scl_oe,
  input wire logic sda_oe,
  // far side pull-downs, commanded by the scenario
  input wire logic slave_stretch,
  input wire logic other_sda_low,
  // line levels seen by everyone
  output logic scl_line,
  output logic sda_line
);
  // pull-ups win only when nobody pulls, so a released line reads 1
  assign scl_line = !scl_oe && !slave_stretch;
  assign sda_line = !sda_oe && !other_sda_low;
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// self-checking bench for the ack and stop sequencer
// ----------------------------------------------------------------
module testbench;
  import i2cms_pkg::*;
  logic sys_clk = 0, sys_rst = 1;
  logic scl_in, sda_in, scl_out, sda_out, scl_oe, sda_oe;
  logic [7:0] brg_reload = 8'h03, buf_wr_data = 8'h00, transfer_buffer;
  logic ack_set = 0, ack_data_value = 0, stop_set = 0, byte_done = 0;
  logic tx_drive_bit = 0, tx_bit_valid = 0, start_req = 0, buf_wr = 0;
  logic write_collision_flag_clr = 0, irq_clr = 0, stop_det_clr = 0, arb_lost_clr = 0;
  logic ack_sequence_enable, stop_sequence_enable, write_collision_flag;
  logic serial_irq_flag, stop_detected, start_detected, bus_busy;
  logic arb_lost, start_grant, stretch = 0, other_low = 0;
  int n_mismatch = 0, n_compared = 0, i;

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  i2cms_bus_model bus (.scl_oe(scl_oe), .sda_oe(sda_oe),
    .slave_stretch(stretch), .other_sda_low(other_low),
    .scl_line(scl_in), .sda_line(sda_in));

  i2cms_core DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .brg_reload(brg_reload),
    .ack_set(ack_set), .ack_data_value(ack_data_value),
    .stop_set(stop_set), .byte_done(byte_done),
    .tx_drive_bit(tx_drive_bit), .tx_bit_valid(tx_bit_valid),
    .start_req(start_req), .buf_wr(buf_wr), .buf_wr_data(buf_wr_data),
    .write_collision_flag_clr(write_collision_flag_clr), .irq_clr(irq_clr), .stop_det_clr(stop_det_clr),
    .arb_lost_clr(arb_lost_clr),
    .ack_sequence_enable(ack_sequence_enable),
    .stop_sequence_enable(stop_sequence_enable),
    .write_collision_flag(write_collision_flag),
    .serial_irq_flag(serial_irq_flag), .stop_detected(stop_detected),
    .start_detected(start_detected), .bus_busy(bus_busy),
    .arb_lost(arb_lost), .start_grant(start_grant),
    .transfer_buffer(transfer_buffer));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      n_mismatch++;
    end
  endtask

  task automatic final_report;
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // software write of the transfer buffer, one clock strobe
  task automatic write_buf(input logic [7:0] d);
    buf_wr = 1;
    buf_wr_data = d;
    @(negedge sys_clk);
    buf_wr = 0;
  endtask

  // end of byte: the sequencer parks with the clock held low
  task automatic end_byte;
    byte_done = 1;
    @(negedge sys_clk);
    byte_done = 0;
    @(negedge sys_clk);
  endtask

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence, inputs change at the falling edge
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge sys_clk);
    sys_rst = 0;
    check("busy_rst", {bus_busy, arb_lost, scl_oe, sda_oe, scl_out, sda_out},
      8'h00);
    write_buf(8'h3C);
    @(negedge sys_clk);
    check("buf_idle", transfer_buffer, 8'h3C);
    // ack then nack, each with a stretched clock and a late write
    for (int v = 0; v < 2; v++) begin
      ack_data_value = v[0];
      end_byte();
      check("hold_scl", scl_oe, 1'b1);
      ack_set = 1;
      @(negedge sys_clk);
      ack_set = 0;
      check("ack_en", ack_sequence_enable, 1'b1);
      check("ack_scl", scl_oe, 1'b1);
      write_buf(8'hA5);
      @(negedge sys_clk);
      check("ack_write_collision_flag", write_collision_flag, 1'b1);
      check("ack_buf", transfer_buffer, 8'h3C);
      // the data pin drive is registered, so it shows a clock later
      check("ack_sda", sda_oe, !v[0]);
      stretch = 1;
      repeat (20) @(negedge sys_clk);
      check("ack_stretch", ack_sequence_enable, 1'b1);
      stretch = 0;
      for (i = 0; i < 40 && ack_sequence_enable !== 0; i++)
        @(negedge sys_clk);
      check("ack_done", ack_sequence_enable, 1'b0);
      write_collision_flag_clr = 1;
      @(negedge sys_clk);
      write_collision_flag_clr = 0;
      check("write_collision_flag_clr", write_collision_flag, 1'b0);
      // clock pulled low again, data let go, and no stop on the bus
      check("ack_relow", {scl_oe, sda_oe, stop_detected}, 8'h04);
    end
    // stop sequence with a colliding write
    end_byte();
    stop_set = 1;
    @(negedge sys_clk);
    stop_set = 0;
    @(negedge sys_clk);
    check("stop_sda", {stop_sequence_enable, sda_oe}, 8'h03);
    write_buf(8'h5A);
    @(negedge sys_clk);
    check("stop_write_collision_flag", write_collision_flag, 1'b1);
    check("stop_buf", transfer_buffer, 8'h3C);
    for (i = 0; i < 60 && scl_oe !== 0; i++) @(negedge sys_clk);
    check("stop_sda_held", sda_oe, 1'b1);
    for (i = 0; i < 60 && sda_oe !== 0; i++) @(negedge sys_clk);
    // sda lets go one baud period after the clock, period is reload+1
    check("stop_gap", i >= 3, 1'b1);
    for (i = 0; i < 20 && stop_detected !== 1; i++) @(negedge sys_clk);
    check("stop_det", stop_detected, 1'b1);
    for (i = 0; i < 20 && serial_irq_flag !== 1; i++) @(negedge sys_clk);
    check("stop_irq", {stop_sequence_enable, serial_irq_flag},
      8'h01);
    irq_clr = 1;
    stop_det_clr = 1;
    write_collision_flag_clr = 1;
    @(negedge sys_clk);
    {irq_clr, stop_det_clr, write_collision_flag_clr} = 3'h0;
    check("flags_clr", {serial_irq_flag, stop_detected}, 8'h00);
    // another master starts: no grant until the bus is idle again
    start_req = 1;
    other_low = 1;
    repeat (3) @(negedge sys_clk);
    check("busy", {start_detected, bus_busy, start_grant}, 8'h06);
    // our bit 0 agrees with the wired low: no loss
    tx_bit_valid = 1;
    repeat (2) @(negedge sys_clk);
    check("arb_keep", arb_lost, 1'b0);
    // we release for a 1 but the line stays low: loss
    tx_drive_bit = 1;
    repeat (2) @(negedge sys_clk);
    check("arb_lost", arb_lost, 1'b1);
    check("arb_rel", {scl_oe, sda_oe}, 8'h00);
    tx_bit_valid = 0;
    other_low = 0;
    repeat (3) @(negedge sys_clk);
    check("idle_stop", {stop_detected, bus_busy}, 8'h02);
    arb_lost_clr = 1;
    @(negedge sys_clk);
    arb_lost_clr = 0;
    check("grant", {arb_lost, start_grant}, 8'h01);
    start_req = 0;
    final_report();
  end
endmodule
